// file: hw/peripheral_bus_dma_bridge.sv
// Bridge between the 36-bit backplane and the 18-bit asynchronous peripheral bus
`timescale 1ns/100ps
module peripheral_bus_dma_bridge
	import bridge_pkg::*;
(
	// Clock and reset
	input logic clk,
	input logic rst,
	// APB register slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Backplane arbitration and interrupt
	output logic bpReq,
	input logic bpGrant,
	output logic [2:0] bpPiReq,
	// Backplane strobes
	input logic bpCaIn,
	output logic bpCaOut,
	output logic bpCaOe,
	input logic bpDcIn,
	output logic bpDcOut,
	output logic bpDcOe,
	// Backplane data and parity
	input logic [WORD_W-1:0] bpDataIn,
	output logic [WORD_W-1:0] bpDataOut,
	output logic [WORD_W-1:0] bpDataOe,
	output logic [1:0] bpParOut,
	// Peripheral address, data and control lines
	input logic [HALF_W-1:0] periAddrIn,
	output logic [HALF_W-1:0] periAddrOut,
	output logic periAddrOe,
	input logic [HALF_W-1:0] periDataIn,
	output logic [HALF_W-1:0] periDataOut,
	output logic periDataOe,
	output logic periC1Out,
	output logic periC0Out,
	output logic periCOe,
	// Peripheral handshake lines
	input logic periMsyncIn,
	output logic periMsyncOut,
	output logic periMsyncOe,
	input logic periSsyncIn,
	output logic periSsyncOut,
	output logic periSsyncOe,
	output logic periBbsyNOut,
	output logic periBbsyNOe,
	// Peripheral DMA and interrupt arbitration
	input logic periNprIn,
	output logic periNpgOut,
	input logic periSackIn,
	input logic [7:1] periBrIn,
	output logic periBgOut,
	input logic periIntrIn
);
	// Odd parity over each half of a word
	function automatic logic [1:0] par2(input logic [WORD_W-1:0] x);
		return {~^x[WORD_W-1:HI_LO], ~^x[LO_HI:0]};
	endfunction

	// Highest active peripheral request level, zero when none
	function automatic logic [2:0] prio(input logic [7:1] br);
		logic [2:0] lvl;
		lvl = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (br[i]) begin
				lvl = 3'(i);
			end
		end
		return lvl;
	endfunction

	state_t state_r;
	op_t op_r;
	logic [3:0] adapter_r; // Own adapter number
	logic fault_r; // Sticky pager miss
	logic [HALF_W-1:0] hold_r; // Fast-mode first half
	logic [WORD_W-1:0] asm_r; // Word assembly buffer
	logic [PHYS_HI:0] phys_r; // Paged backplane address
	logic [VEC_W-1:0] vec_r; // Captured interrupt vector
	logic [PG_ENT_W-1:0] lkEntry;
	logic [PG_ENT_W-1:0] rdEntry;
	logic [5:0] idPos;
	logic caFree, ioHit, idHit, pageFault;
	logic apbSetup, apbWrite, pgHit;

	// Command/address decode of cycles other masters drive
	assign caFree = bpCaIn && !bpCaOe;
	assign ioHit = caFree && bpDataIn[BIT_IO] && bpDataIn[DEV_HI:DEV_LO] == adapter_r;
	assign idHit = caFree && bpDataIn[BIT_IO] && bpDataIn[BIT_DEVRD] && bpPiReq != 3'h0
		&& bpDataIn[PILVL_HI:PILVL_LO] == bpPiReq
		&& adapter_r >= ADAPTER_MIN && adapter_r <= ADAPTER_MAX;
	assign idPos = IDENT_TOP - {2'h0, adapter_r};
	assign pageFault = state_r == S_DMA_MSYNC && periMsyncIn && !lkEntry[ENT_VALID];

	// APB phases; pready is always high so each access takes one cycle
	assign apbSetup = psel && !penable;
	assign apbWrite = psel && penable && pready && pwrite;
	assign pgHit = paddr[PG_WIN_HI:PG_WIN_LO] == 3'h0;

	// Pager, read by software and by the DMA path
	dma_pager u_pager (
		.clk(clk),
		.rst(rst),
		.wrEn(apbWrite && pgHit),
		.wrIdx(paddr[APB_IDX_HI:APB_IDX_LO]),
		.wrEntry(pwdata[PG_ENT_W-1:0]),
		.rdIdx(paddr[APB_IDX_HI:APB_IDX_LO]),
		.rdEntry(rdEntry),
		.lkIdx(periAddrIn[PG_IDX_HI:PG_IDX_LO]),
		.lkEntry(lkEntry)
	);

	// APB slave: read data latched in setup so it is stable in access
	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			adapter_r <= ADAPTER_RST;
		end else begin
			pready <= 1'b1;
			if (apbSetup) begin
				pslverr <= !(pgHit || paddr == OFF_CTRL || paddr == OFF_STATUS);
				prdata <= 32'h0000_0000;
				if (pgHit) begin
					prdata[PG_ENT_W-1:0] <= rdEntry;
				end else if (paddr == OFF_CTRL) begin
					prdata[CTRL_ADP_HI:0] <= adapter_r;
				end else if (paddr == OFF_STATUS) begin
					prdata[ST_BUSY] <= state_r != S_IDLE;
					prdata[ST_FAULT] <= fault_r;
					prdata[ST_DMA] <= state_r == S_DMA_MSYNC || state_r == S_DMA_END;
					prdata[ST_PI_HI:ST_PI_LO] <= bpPiReq;
				end
			end
			// Adapter number steers the I/O decode
			if (apbWrite && paddr == OFF_CTRL) begin
				adapter_r <= pwdata[CTRL_ADP_HI:0];
			end
		end
	end

	// Pager miss flag: a new miss wins over a write-one-to-clear
	always_ff @(posedge clk) begin
		if (rst) begin
			fault_r <= 1'b0;
		end else if (pageFault) begin
			fault_r <= 1'b1;
		end else if (apbWrite && paddr == OFF_STATUS && pwdata[ST_FAULT]) begin
			fault_r <= 1'b0;
		end
	end

	// Interrupt encoder: any level 1 to 7 becomes a backplane request
	always_ff @(posedge clk) begin
		if (rst) begin
			bpPiReq <= 3'h0;
		end else begin
			bpPiReq <= prio(periBrIn);
		end
	end

	// Main sequencer; drives every bus pin except bpPiReq from flip-flops
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= S_IDLE;
			op_r <= OP_NONE;
			hold_r <= '0;
			asm_r <= '0;
			phys_r <= '0;
			vec_r <= '0;
			bpReq <= 1'b0;
			bpCaOut <= 1'b0;
			bpCaOe <= 1'b0;
			bpDcOut <= 1'b0;
			bpDcOe <= 1'b0;
			bpDataOut <= '0;
			bpDataOe <= '0;
			bpParOut <= 2'h0;
			periAddrOut <= '0;
			periAddrOe <= 1'b0;
			periDataOut <= '0;
			periDataOe <= 1'b0;
			periC1Out <= 1'b0;
			periC0Out <= 1'b0;
			periCOe <= 1'b0;
			periMsyncOut <= 1'b0;
			periMsyncOe <= 1'b0;
			periSsyncOut <= 1'b0;
			periSsyncOe <= 1'b0;
			periBbsyNOut <= 1'b0;
			periBbsyNOe <= 1'b0;
			periNpgOut <= 1'b0;
			periBgOut <= 1'b0;
		end else begin
			case (state_r)
				S_IDLE: begin
					// Backplane cycles first; DMA starts unless an identify or I/O cycle hits this adapter
					if (idHit) begin
						bpDataOut <= '0;
						bpDataOe <= '0;
						bpDataOut[idPos] <= 1'b1;
						bpDataOe[idPos] <= 1'b1;
						state_r <= S_ID_DRIVE;
					end else if (ioHit && bpDataIn[BIT_WR]) begin
						periAddrOut <= bpDataIn[PADDR_HI:0];
						periC1Out <= bpDataIn[BIT_WR];
						periC0Out <= 1'b0;
						state_r <= S_IOW_DATA;
					end else if (ioHit && bpDataIn[BIT_RD]) begin
						periBgOut <= 1'b1;
						state_r <= S_VEC_WAIT;
					end else if (periNprIn) begin
						periNpgOut <= 1'b1;
						state_r <= S_NPG;
					end
				end
				S_ID_DRIVE: begin
					// Identify line is pulled for one cycle only
					bpDataOut <= '0;
					bpDataOe <= '0;
					state_r <= S_IDLE;
				end
				S_IOW_DATA: begin
					if (bpDcIn) begin
						periDataOut <= bpDataIn[PADDR_HI:0];
						periDataOe <= 1'b1;
						periAddrOe <= 1'b1;
						periCOe <= 1'b1;
						periMsyncOe <= 1'b1;
						periBbsyNOe <= 1'b1;
						state_r <= S_PB_SETUP;
					end
				end
				S_PB_SETUP: begin
					// One cycle of deskew before the strobe
					periMsyncOut <= 1'b1;
					state_r <= S_PB_SYNC;
				end
				S_PB_SYNC: begin
					if (periSsyncIn) begin
						periMsyncOut <= 1'b0;
						state_r <= S_PB_END;
					end
				end
				S_PB_END: begin
					// Release only after the slave has dropped its reply
					if (!periSsyncIn) begin
						periAddrOe <= 1'b0;
						periDataOe <= 1'b0;
						periCOe <= 1'b0;
						periMsyncOe <= 1'b0;
						periBbsyNOe <= 1'b0;
						state_r <= S_IDLE;
					end
				end
				S_NPG: begin
					if (periSackIn) begin
						periNpgOut <= 1'b0;
						state_r <= S_DMA_MSYNC;
					end
				end
				S_DMA_MSYNC: begin
					if (periMsyncIn) begin
						phys_r <= {lkEntry[PG_FRAME_W-1:0],
							periAddrIn[PG_OFF_HI:PG_OFF_LO]};
						periSsyncOut <= 1'b1;
						periSsyncOe <= 1'b1;
						op_r <= OP_NONE;
						if (!lkEntry[ENT_VALID]) begin
							// Invalid page: accept and drop the half
							op_r <= OP_NONE;
						end else if (lkEntry[ENT_FAST] && !periAddrIn[ADDR_HALF]) begin
							hold_r <= periDataIn;
						end else if (lkEntry[ENT_FAST]) begin
							asm_r <= {hold_r, periDataIn};
							op_r <= OP_FULL;
						end else if (!periAddrIn[ADDR_HALF]) begin
							asm_r[WORD_W-1:HI_LO] <= periDataIn;
							op_r <= OP_LOW;
						end else begin
							asm_r[LO_HI:0] <= periDataIn;
							op_r <= OP_PAUSE;
						end
						state_r <= S_DMA_END;
					end else if (!periSackIn) begin
						state_r <= S_IDLE;
					end
				end
				S_DMA_END: begin
					// The peripheral waits on us while the backplane is busy
					if (!periMsyncIn) begin
						periSsyncOut <= 1'b0;
						periSsyncOe <= 1'b0;
						if (op_r == OP_NONE) begin
							state_r <= periSackIn ? S_DMA_MSYNC : S_IDLE;
						end else begin
							bpReq <= 1'b1;
							state_r <= S_BP_REQ;
						end
					end
				end
				S_VEC_WAIT: begin
					if (periIntrIn) begin
						vec_r <= periDataIn[VEC_W-1:0];
						periBgOut <= 1'b0;
						periSsyncOut <= 1'b1;
						periSsyncOe <= 1'b1;
						state_r <= S_VEC_END;
					end
				end
				S_VEC_END: begin
					if (!periIntrIn) begin
						periSsyncOut <= 1'b0;
						periSsyncOe <= 1'b0;
						op_r <= OP_VEC;
						bpReq <= 1'b1;
						state_r <= S_BP_REQ;
					end
				end
				S_BP_REQ: begin
					// No strobe or data line is driven on the backplane before the grant
					if (bpGrant) begin
						bpDataOe <= '1;
						if (op_r == OP_VEC) begin
							bpDataOut <= {20'h0_0000, vec_r};
							bpParOut <= par2({20'h0_0000, vec_r});
							bpDcOut <= 1'b1;
							bpDcOe <= 1'b1;
							state_r <= S_BP_DATA;
						end else begin
							bpDataOut <= '0;
							bpDataOut[PHYS_HI:0] <= phys_r;
							bpDataOut[BIT_WR] <= 1'b1;
							bpDataOut[BIT_RD] <= op_r == OP_PAUSE;
							// Parity covers the read and write bits as driven
							bpParOut <= par2({1'b0, op_r == OP_PAUSE, 1'b1, 11'h000, phys_r});
							bpCaOut <= 1'b1;
							bpCaOe <= 1'b1;
							state_r <= S_BP_CA;
						end
					end
				end
				S_BP_CA: begin
					bpCaOut <= 1'b0;
					bpCaOe <= 1'b0;
					if (op_r == OP_PAUSE) begin
						bpDataOe <= '0;
						state_r <= S_BP_MEMWAIT;
					end else begin
						bpDataOut <= asm_r;
						bpParOut <= par2(asm_r);
						bpDcOut <= 1'b1;
						bpDcOe <= 1'b1;
						state_r <= S_BP_DATA;
					end
				end
				S_BP_MEMWAIT: begin
					// Memory's own data cycle comes first, then ours
					if (bpDcIn) begin
						bpDataOut <= {bpDataIn[WORD_W-1:HI_LO], asm_r[LO_HI:0]};
						bpParOut <= par2({bpDataIn[WORD_W-1:HI_LO], asm_r[LO_HI:0]});
						bpDataOe <= '1;
						bpDcOut <= 1'b1;
						bpDcOe <= 1'b1;
						state_r <= S_BP_DATA;
					end
				end
				S_BP_DATA: begin
					bpDcOut <= 1'b0;
					bpDcOe <= 1'b0;
					bpDataOe <= '0;
					bpReq <= 1'b0;
					state_r <= (op_r != OP_VEC && periSackIn) ? S_DMA_MSYNC : S_IDLE;
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// Checks on the sequencer
	property p_grant;
		@(posedge clk) disable iff (rst) $rose(bpCaOut) || $rose(bpDcOut) |-> bpReq && $past(bpGrant);
	endproperty
	a_grant: assert property (p_grant) else $error("backplane strobe without grant");

	property p_ioaddr;
		@(posedge clk) disable iff (rst)
		state_r == S_IDLE && !idHit && ioHit && bpDataIn[BIT_WR]
		|=> periAddrOut == $past(bpDataIn[PADDR_HI:0]) && periC1Out;
	endproperty
	a_ioaddr: assert property (p_ioaddr) else $error("I/O address or C1 not routed");

	property p_msync;
		@(posedge clk) disable iff (rst)
		$rose(periMsyncOut) |-> $past(periAddrOe) && $past(periDataOe) && periBbsyNOe;
	endproperty
	a_msync: assert property (p_msync) else $error("MSYNC before lines and BBSY");

	property p_npg;
		@(posedge clk) disable iff (rst)
		state_r == S_IDLE && !caFree && periNprIn |=> periNpgOut;
	endproperty
	a_npg: assert property (p_npg) else $error("DMA request not granted");

	property p_hold;
		@(posedge clk) disable iff (rst)
		state_r == S_DMA_MSYNC && periMsyncIn && lkEntry[ENT_VALID] && lkEntry[ENT_FAST]
		&& !periAddrIn[ADDR_HALF] |=> hold_r == $past(periDataIn) && op_r == OP_NONE ##1 !bpReq;
	endproperty
	a_hold: assert property (p_hold) else $error("fast first half mishandled");

	property p_join;
		@(posedge clk) disable iff (rst)
		state_r == S_DMA_MSYNC && periMsyncIn && lkEntry[ENT_VALID] && lkEntry[ENT_FAST]
		&& periAddrIn[ADDR_HALF] |=> asm_r == {$past(hold_r), $past(periDataIn)};
	endproperty
	a_join: assert property (p_join) else $error("fast word not assembled");

	property p_cmd;
		@(posedge clk) disable iff (rst)
		bpCaOut |-> !bpDataOut[BIT_IO] && bpDataOut[BIT_WR] && bpDataOut[PHYS_HI:0] == phys_r;
	endproperty
	a_cmd: assert property (p_cmd) else $error("memory command word wrong");

	property p_par;
		@(posedge clk) disable iff (rst) bpDcOut |-> bpParOut == par2(bpDataOut);
	endproperty
	a_par: assert property (p_par) else $error("data cycle parity wrong");

	property p_pause;
		@(posedge clk) disable iff (rst)
		state_r == S_BP_MEMWAIT && bpDcIn
		|=> bpDcOut && bpDataOut[LO_HI:0] == asm_r[LO_HI:0] ##1 !bpDcOut;
	endproperty
	a_pause: assert property (p_pause) else $error("second data cycle missing");

	property p_pi;
		@(posedge clk) disable iff (rst) |periBrIn |=> bpPiReq != 3'h0;
	endproperty
	a_pi: assert property (p_pi) else $error("request level not encoded");

	property p_ident;
		@(posedge clk) disable iff (rst)
		state_r == S_IDLE && idHit |=> $onehot(bpDataOe) && bpDataOe[idPos] ##1 bpDataOe == '0;
	endproperty
	a_ident: assert property (p_ident) else $error("identify line wrong");

	property p_vector;
		@(posedge clk) disable iff (rst)
		bpDcOut && op_r == OP_VEC |-> bpDataOut[VEC_W-1:0] == vec_r && !bpCaOut;
	endproperty
	a_vector: assert property (p_vector) else $error("vector not delivered");

	property p_foreign;
		@(posedge clk) disable iff (rst)
		state_r == S_IDLE && caFree && bpDataIn[DEV_HI:DEV_LO] != adapter_r && !idHit
		&& !periNprIn |=> state_r == S_IDLE;
	endproperty
	a_foreign: assert property (p_foreign) else $error("foreign I/O cycle accepted");

	c_fast: cover property (@(posedge clk) disable iff (rst) bpCaOut && op_r == OP_FULL);
	c_pause: cover property (@(posedge clk) disable iff (rst) state_r == S_BP_MEMWAIT && bpDcIn);
	c_vec: cover property (@(posedge clk) disable iff (rst) bpDcOut && op_r == OP_VEC);
	c_iow: cover property (@(posedge clk) disable iff (rst) $rose(periMsyncOut));
endmodule

// file: hw/bridge_pkg.sv
// Shared constants for the backplane to peripheral bus DMA bridge
package bridge_pkg;
	// Backplane word: bit n of the printed numbering sits at index 35-n
	localparam int WORD_W = 36;
	localparam int HALF_W = 18;
	localparam int BIT_IO = 35;
	localparam int BIT_RD = 34;
	localparam int BIT_WR = 33;
	localparam int BIT_DEVRD = 31;
	localparam int DEV_HI = 21;
	localparam int DEV_LO = 18;
	localparam int PADDR_HI = 17;
	localparam int PHYS_HI = 21;
	localparam int PILVL_HI = 20;
	localparam int PILVL_LO = 18;
	localparam int VEC_W = 16;
	localparam int HI_LO = 18;
	localparam int LO_HI = 17;
	// Identify lines: adapter k pulls index IDENT_TOP - k
	localparam logic [5:0] IDENT_TOP = 6'h11;
	localparam logic [3:0] ADAPTER_MIN = 4'h1;
	localparam logic [3:0] ADAPTER_MAX = 4'h5;
	localparam logic [3:0] ADAPTER_RST = 4'h1;
	// Peripheral address split for the pager
	localparam int PG_IDX_HI = 17;
	localparam int PG_IDX_LO = 11;
	localparam int PG_OFF_HI = 10;
	localparam int PG_OFF_LO = 2;
	localparam int ADDR_HALF = 1;
	localparam int PG_IDX_W = 7;
	localparam int PG_ENTRIES = 128;
	localparam int PG_FRAME_W = 13;
	localparam int PG_ENT_W = 15;
	localparam int ENT_VALID = 14;
	localparam int ENT_FAST = 13;
	// APB map
	localparam logic [11:0] OFF_CTRL = 12'h200;
	localparam logic [11:0] OFF_STATUS = 12'h204;
	localparam int PG_WIN_HI = 11;
	localparam int PG_WIN_LO = 9;
	localparam int APB_IDX_HI = 8;
	localparam int APB_IDX_LO = 2;
	localparam int CTRL_ADP_HI = 3;
	localparam int ST_BUSY = 0;
	localparam int ST_FAULT = 1;
	localparam int ST_DMA = 2;
	localparam int ST_PI_LO = 3;
	localparam int ST_PI_HI = 5;
	// Bridge sequencer states
	typedef enum logic [3:0] {S_IDLE, S_ID_DRIVE, S_IOW_DATA, S_PB_SETUP, S_PB_SYNC,
		S_PB_END, S_NPG, S_DMA_MSYNC, S_DMA_END, S_VEC_WAIT, S_VEC_END, S_BP_REQ,
		S_BP_CA, S_BP_MEMWAIT, S_BP_DATA} state_t;
	// Pending backplane operation
	typedef enum logic [2:0] {OP_NONE, OP_FULL, OP_LOW, OP_PAUSE, OP_VEC} op_t;
endpackage

// file: hw/dma_pager.sv
// Pager table: peripheral page index to backplane frame, with valid and 36-bit enable
`timescale 1ns/100ps
module dma_pager
	import bridge_pkg::*;
(
	// Clock and reset
	input logic clk,
	input logic rst,
	// Software write port
	input logic wrEn,
	input logic [PG_IDX_W-1:0] wrIdx,
	input logic [PG_ENT_W-1:0] wrEntry,
	// Software read port
	input logic [PG_IDX_W-1:0] rdIdx,
	output logic [PG_ENT_W-1:0] rdEntry,
	// Translation lookup
	input logic [PG_IDX_W-1:0] lkIdx,
	output logic [PG_ENT_W-1:0] lkEntry
);
	// One entry per page; cleared so no stale page is valid after reset
	logic [PG_ENT_W-1:0] table_r [PG_ENTRIES];

	// Table update
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < PG_ENTRIES; i++) begin
				table_r[i] <= '0;
			end
		end else if (wrEn) begin
			table_r[wrIdx] <= wrEntry;
		end
	end

	// Lookup is combinational so the sequencer sees it in the strobe cycle
	assign rdEntry = table_r[rdIdx];
	assign lkEntry = table_r[lkIdx];
endmodule

// file: tb/bp_partner.sv
// Backplane partner: console arbiter, memory and processor cycles
`timescale 1ns/100ps
module bp_partner (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bridge side of the backplane
	input wire logic bpReq,
	input wire logic bpCaOe,
	input wire logic bpDcOe,
	input wire logic [35:0] bpDataOut,
	input wire logic [1:0] bpParOut,
	// Partner drives
	output logic bpGrant,
	output logic bpCaIn,
	output logic bpDcIn,
	output logic [35:0] bpDataIn
);
	localparam logic [35:0] MEM_WORD = 36'h5_a5a5_c3c3; // Memory answer to a pause read
	logic grantDly; // Request seen a cycle ago
	logic memOn; // Memory data cycle on the bus
	logic [2:0] memWait; // Cycles until memory answers
	logic [35:0] lastDrv; // Inverted on release so stale data never looks valid
	logic [35:0] caW; // Last bridge command word
	logic [35:0] dcW; // Last bridge data word
	logic [1:0] dcPar; // Its parity
	logic caNoGrant; // Bridge strobed without grant
	int dcCount; // Bridge data cycles seen

	initial begin
		{bpGrant, bpCaIn, bpDcIn, grantDly, memOn, caNoGrant} = '0;
		{bpDataIn, lastDrv, caW, dcW, dcPar, memWait} = '0;
		dcCount = 0;
	end

	// Grant two cycles after request, dropped one cycle after it
	always @(posedge clk) begin
		grantDly <= bpReq && !rst;
		bpGrant <= grantDly && bpReq;
	end

	// Capture bridge cycles; memory answers a read/pause-write late on purpose
	always @(posedge clk) begin
		if (bpCaOe) begin
			caW <= bpDataOut;
			caNoGrant <= caNoGrant | !bpGrant;
		end
		if (bpCaOe && bpDataOut[34] && !bpDataOut[35])
			memWait <= 3'h3;
		else if (memWait != 3'h0)
			memWait <= memWait - 3'h1;
		if (bpDcOe) begin
			dcW <= bpDataOut;
			dcPar <= bpParOut;
			dcCount <= dcCount + 1;
		end
		if (memWait == 3'h1) begin
			memOn <= 1'b1;
			bpDcIn <= 1'b1;
			bpDataIn <= MEM_WORD;
			lastDrv <= MEM_WORD;
		end else if (memOn) begin
			memOn <= 1'b0;
			bpDcIn <= 1'b0;
			bpDataIn <= ~lastDrv;
		end
	end

	// One processor command or data cycle, granted beforehand
	task cycle(input logic isData, input logic [35:0] w);
		@(posedge clk);
		if (isData)
			bpDcIn <= 1'b1;
		else
			bpCaIn <= 1'b1;
		bpDataIn <= w;
		lastDrv <= w;
		@(posedge clk);
		bpCaIn <= 1'b0;
		bpDcIn <= 1'b0;
		bpDataIn <= ~w;
	endtask
endmodule

// file: tb/tb_top.sv
// Bridge bench: registers, processor write, DMA halves, interrupts
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin errCount++; \
	$display("unexpected %s exp %h got %h", nm, exp, got); end end
`define WAITC(c) begin n = 0; do begin @(posedge clk); #1; n++; end \
	while (!(c) && n < 500); if (n >= 500) begin errCount++; endSim(); end end
module tb_top;
	import bridge_pkg::*;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, rdErr;
	logic [11:0] paddr; // APB request
	logic [31:0] pwdata, prdata, rdVal;
	logic bpReq, bpGrant, bpCaIn, bpCaOe, bpDcIn, bpDcOe; // Backplane strobes
	logic [2:0] bpPiReq;
	logic [35:0] bpDataIn, bpDataOut, bpDataOe, w;
	logic [1:0] bpParOut;
	logic [17:0] periAddrIn, periAddrOut, periDataIn, periDataOut; // Peripheral lines
	logic periAddrOe, periDataOe, periC1Out, periMsyncIn, periMsyncOut, periSsyncIn, periC0Out;
	logic periCOe; // Control line drive
	logic periSsyncOut, periBbsyNOe, periNprIn, periNpgOut, periSackIn, periBgOut, periIntrIn;
	logic [7:1] periBrIn; // Request levels
	int errCount, checked, n, lv;

	peripheral_bus_dma_bridge peripheral_bus_dma_bridge_inst (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bpReq(bpReq),
		.bpGrant(bpGrant), .bpPiReq(bpPiReq), .bpCaIn(bpCaIn), .bpCaOut(), .bpCaOe(bpCaOe),
		.bpDcIn(bpDcIn), .bpDcOut(), .bpDcOe(bpDcOe), .bpDataIn(bpDataIn),
		.bpDataOut(bpDataOut), .bpDataOe(bpDataOe), .bpParOut(bpParOut),
		.periAddrIn(periAddrIn), .periAddrOut(periAddrOut), .periAddrOe(periAddrOe),
		.periDataIn(periDataIn), .periDataOut(periDataOut), .periDataOe(periDataOe),
		.periC1Out(periC1Out), .periC0Out(periC0Out), .periCOe(periCOe),
		.periMsyncIn(periMsyncIn),
		.periMsyncOut(periMsyncOut), .periMsyncOe(), .periSsyncIn(periSsyncIn),
		.periSsyncOut(periSsyncOut), .periSsyncOe(), .periBbsyNOut(),
		.periBbsyNOe(periBbsyNOe), .periNprIn(periNprIn), .periNpgOut(periNpgOut),
		.periSackIn(periSackIn), .periBrIn(periBrIn), .periBgOut(periBgOut),
		.periIntrIn(periIntrIn));

	bp_partner bp_partner_inst (.clk(clk), .rst(rst), .bpReq(bpReq), .bpCaOe(bpCaOe),
		.bpDcOe(bpDcOe), .bpDataOut(bpDataOut), .bpParOut(bpParOut), .bpGrant(bpGrant),
		.bpCaIn(bpCaIn), .bpDcIn(bpDcIn), .bpDataIn(bpDataIn));

	// 200 MHz clock
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	// Verdict and end of run
	task endSim;
		$display("compared %0d mismatches %0d", checked, errCount);
		if (errCount == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One APB transfer; request held until pready is sampled
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
		rdVal = prdata;
		rdErr = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 50) begin errCount++; endSim(); end
	endtask

	// Peripheral master word: lines settle before MSYNC, released after SSYNC drops
	task msync(input logic [17:0] a, input logic [17:0] d);
		@(posedge clk);
		periAddrIn <= a;
		periDataIn <= d;
		@(posedge clk);
		periMsyncIn <= 1;
		`WAITC(periSsyncOut === 1'b1)
		@(posedge clk);
		periMsyncIn <= 0;
		`WAITC(periSsyncOut === 1'b0)
		periAddrIn <= ~a;
		periDataIn <= ~d;
	endtask

	// Main sequence
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		{periAddrIn, periDataIn, periMsyncIn, periSsyncIn, periNprIn} = '0;
		{periSackIn, periBrIn, periIntrIn, errCount, checked} = '0;
		repeat (5) @(posedge clk);
		rst <= 0;
		apb(1, OFF_CTRL, 32'h0000_0003);
		apb(0, OFF_CTRL, 32'h0);
		`CHK("adapter", 4'h3, rdVal[3:0])
		apb(0, 12'h300, 32'h0);
		`CHK("unmapped", 1'b1, rdErr)
		apb(1, 12'h014, 32'h0000_6123);
		apb(1, 12'h018, 32'h0000_4045);
		apb(0, 12'h014, 32'h0);
		`CHK("page entry", 15'h6123, rdVal[14:0])
		// Write for adapter 4 must leave the peripheral bus alone
		bp_partner_inst.cycle(0, 36'ha_0012_5a24);
		repeat (4) @(posedge clk);
		#1;
		`CHK("other adapter", 1'b0, periC1Out)
		bp_partner_inst.cycle(0, 36'ha_000e_5a24);
		#1;
		`CHK("peri addr", 18'h2_5a24, periAddrOut)
		`CHK("c1 line", 1'b1, periC1Out)
		bp_partner_inst.cycle(1, 36'h0_0000_0039);
		`WAITC(periMsyncOut === 1'b1)
		`CHK("peri data", 18'h0_0039, periDataOut)
		`CHK("bus busy", 1'b1, periBbsyNOe)
		`CHK("addr drive", 1'b1, periAddrOe)
		`CHK("ctl drive", 1'b1, periCOe)
		`CHK("c0 line", 1'b0, periC0Out)
		periSsyncIn <= 1;
		`WAITC(periMsyncOut === 1'b0)
		periSsyncIn <= 0;
		`WAITC(periDataOe === 1'b0)
		// DMA ownership, then a fast pair
		periNprIn <= 1;
		`WAITC(periNpgOut === 1'b1)
		periSackIn <= 1;
		periNprIn <= 0;
		`WAITC(periNpgOut === 1'b0)
		msync(18'h0_2a80, 18'h1_2345);
		repeat (4) @(posedge clk);
		#1;
		`CHK("no early write", 0, bp_partner_inst.dcCount)
		msync(18'h0_2a82, 18'h2_6789);
		`WAITC(bp_partner_inst.dcCount == 1)
		w = bp_partner_inst.caW;
		`CHK("fast ca", {3'b001, 22'h2_46a0}, {w[35:33], w[21:0]})
		`CHK("fast data", {18'h1_2345, 18'h2_6789}, bp_partner_inst.dcW)
		`CHK("fast par", {~^18'h1_2345, ~^18'h2_6789}, bp_partner_inst.dcPar)
		// Slow pair: low half write, then read/pause-write
		msync(18'h0_3044, 18'h0_abcd);
		`WAITC(bp_partner_inst.dcCount == 2)
		w = bp_partner_inst.caW;
		`CHK("slow ca", {3'b001, 22'h0_8a11}, {w[35:33], w[21:0]})
		`CHK("slow low", 18'h0_abcd, bp_partner_inst.dcW[35:18])
		msync(18'h0_3046, 18'h3_0f0f);
		`WAITC(bp_partner_inst.dcCount == 3)
		w = bp_partner_inst.caW;
		`CHK("pause ca", {3'b011, 22'h0_8a11}, {w[35:33], w[21:0]})
		`CHK("pause data", {18'h1_6969, 18'h3_0f0f}, bp_partner_inst.dcW)
		periSackIn <= 0;
		// Levels 2 and 5 pending: highest goes to the backplane
		periBrIn <= 7'b001_0010;
		repeat (3) @(posedge clk);
		#1;
		`CHK("pi level", 3'h5, bpPiReq)
		for (lv = 4; lv < 6; lv++) begin
			bp_partner_inst.cycle(0, {8'h88, 7'h0, 3'(lv), 18'h0});
			#1;
			`CHK("ident", lv == 5, bpDataOut[14] & bpDataOe[14])
		end
		bp_partner_inst.cycle(0, 36'hc_000c_0000);
		`WAITC(periBgOut === 1'b1)
		periDataIn <= 18'h0_0154;
		periIntrIn <= 1;
		`WAITC(periSsyncOut === 1'b1)
		`CHK("grant off", 1'b0, periBgOut)
		periIntrIn <= 0;
		periBrIn <= '0;
		`WAITC(bp_partner_inst.dcCount == 4)
		`CHK("vector", 16'h0154, bp_partner_inst.dcW[15:0])
		`CHK("ungranted", 1'b0, bp_partner_inst.caNoGrant)
		endSim();
	end
endmodule
